// ==== lede_regs.v ====
// Purpose: leading edge detector register file with AXI4-Lite slave and timestamp adjust
// Assumes: accumulator samples and raw timestamp come from logic on aclk
// Notes:   byte address = sub-offset index * 4; 16-bit values use byte lanes 0 and 1
//
// Behaviour
// - detector scans accumulator response for first path, feeding timestamp and diagnostics
// - read-only 16-bit threshold report holds threshold used for first path search
// - threshold is derived from a noise estimate made during the scan
// - five-bit noise multiplier, low config bits, reset 12, scales noise level
// - three-bit peak multiplier, high config bits, reset 3 meaning 1.5
// - read-only 16-bit peak position, updated each analysis pass
// - read-only 16-bit peak magnitude at the reported position
// - read-write 16-bit receive antenna delay register
// - delay counts system time units of about 15.65 ps
// - adjusted stamp is raw minus antenna delay minus first path offset
`timescale 1ns/1ps
`include "lede_map.vh"

module lede_regs #(
  parameter IDX_W = 16,
  parameter MAG_W = 16,
  parameter NOISE_LOG2 = 4,
  parameter TS_W = 40,
  parameter [15:0] TAP_TICKS = 16'h0040
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // ==========================================
  // AXI4-Lite slave
  input wire [15:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [15:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // ==========================================
  // accumulator stream and timestamps
  input wire acc_start,
  input wire acc_valid,
  input wire [MAG_W-1:0] acc_mag,
  input wire acc_last,
  input wire [TS_W-1:0] raw_receive_timestamp,
  output reg [TS_W-1:0] rx_stamp_ff,
  output reg rx_stamp_vld_ff,
  output reg [15:0] tuning_cfg_ff,
  output reg [15:0] replica_coef_ff
);
  // ==========================================
  // register state
  reg [7:0] thr_cfg_ff;
  reg [15:0] antd_ff;
  reg [15:0] thr_rpt_ff;
  reg [15:0] pk_pos_ff;
  reg [15:0] pk_mag_ff;
  reg [TS_W-1:0] raw_hold_ff;

  reg aw_held_ff;
  reg [15:0] awaddr_ff;
  reg w_held_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  wire scan_done;
  wire [MAG_W-1:0] scan_thr;
  wire [IDX_W-1:0] scan_fp;
  wire [IDX_W-1:0] scan_pi;
  wire [MAG_W-1:0] scan_pm;

  // ==========================================
  // detector core
  lede_scan #(
    .IDX_W(IDX_W),
    .MAG_W(MAG_W),
    .NOISE_LOG2(NOISE_LOG2)
  ) u_scan (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .noise_threshold_multiplier(thr_cfg_ff[`LEDE_NTM_MSB:`LEDE_NTM_LSB]),
    .peak_noise_multiplier(thr_cfg_ff[`LEDE_PEAK_NOISE_MULTIPLIER_MSB:`LEDE_PEAK_NOISE_MULTIPLIER_LSB]),
    .acc_start(acc_start),
    .acc_valid(acc_valid),
    .acc_mag(acc_mag),
    .acc_last(acc_last),
    .done_ff(scan_done),
    .thr_ff(scan_thr),
    .fp_idx_ff(scan_fp),
    .pk_idx_ff(scan_pi),
    .pk_mag_ff(scan_pm)
  );

  // ==========================================
  // timestamp adjustment
  // first path normally precedes the peak; a later one is treated as no offset
  wire [IDX_W-1:0] fp_gap = (scan_pi > scan_fp) ? (scan_pi - scan_fp) : {IDX_W{1'b0}};
  wire [IDX_W+15:0] gap_ticks = fp_gap * TAP_TICKS;
  wire [TS_W-1:0] antd_ext = {{(TS_W-16){1'b0}}, antd_ff};
  wire [TS_W-1:0] gap_ext = {{(TS_W-IDX_W-16){1'b0}}, gap_ticks};
  wire [TS_W-1:0] adj_stamp = raw_hold_ff - antd_ext - gap_ext;

  always @(posedge aclk) begin
    if (!aresetn) begin
      raw_hold_ff <= {TS_W{1'b0}};
      rx_stamp_ff <= {TS_W{1'b0}};
      rx_stamp_vld_ff <= 1'b0;
      thr_rpt_ff <= `LEDE_STATUS_RST;
      pk_pos_ff <= `LEDE_STATUS_RST;
      pk_mag_ff <= `LEDE_STATUS_RST;
    end else if (ce) begin
      rx_stamp_vld_ff <= 1'b0;
      // the raw stamp is taken when a frame's scan starts
      if (acc_start) begin
        raw_hold_ff <= raw_receive_timestamp;
      end
      if (scan_done) begin
        rx_stamp_ff <= adj_stamp;
        rx_stamp_vld_ff <= 1'b1;
        thr_rpt_ff <= scan_thr[15:0];
        pk_pos_ff <= scan_pi[15:0];
        pk_mag_ff <= scan_pm[15:0];
      end
    end
  end

  // ==========================================
  // write channel: address and data taken in either order
  assign awready = ce && !aw_held_ff && !bvalid;
  assign wready = ce && !w_held_ff && !bvalid;
  wire do_write = aw_held_ff && w_held_ff && !bvalid;
  wire [`LEDE_IDX_W-1:0] wr_idx = awaddr_ff[15:2];

  reg wr_hit;
  always @* begin
    case (wr_idx)
      `LEDE_IDX_CFG1: wr_hit = 1'b1;
      `LEDE_IDX_RXANTD: wr_hit = 1'b1;
      `LEDE_IDX_CFG2: wr_hit = 1'b1;
      `LEDE_IDX_REPC: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 16'h0000;
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `LEDE_RESP_OKAY;
      thr_cfg_ff <= `LEDE_CFG1_RST;
      antd_ff <= `LEDE_RXANTD_RST;
      tuning_cfg_ff <= `LEDE_CFG2_RST;
      replica_coef_ff <= `LEDE_REPC_RST;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid <= 1'b1;
        // reserved and read-only locations keep their state
        bresp <= wr_hit ? `LEDE_RESP_OKAY : `LEDE_RESP_SLVERR;
        case (wr_idx)
          `LEDE_IDX_CFG1: begin
            // one octet only; upper lanes never reach neighbouring bytes
            if (wstrb_ff[0]) begin
              thr_cfg_ff <= wdata_ff[7:0];
            end
          end
          `LEDE_IDX_RXANTD: begin
            if (wstrb_ff[0]) begin
              antd_ff[7:0] <= wdata_ff[7:0];
            end
            if (wstrb_ff[1]) begin
              antd_ff[15:8] <= wdata_ff[15:8];
            end
          end
          `LEDE_IDX_CFG2: begin
            if (wstrb_ff[0]) begin
              tuning_cfg_ff[7:0] <= wdata_ff[7:0];
            end
            if (wstrb_ff[1]) begin
              tuning_cfg_ff[15:8] <= wdata_ff[15:8];
            end
          end
          `LEDE_IDX_REPC: begin
            if (wstrb_ff[0]) begin
              replica_coef_ff[7:0] <= wdata_ff[7:0];
            end
            if (wstrb_ff[1]) begin
              replica_coef_ff[15:8] <= wdata_ff[15:8];
            end
          end
          default: begin
            thr_cfg_ff <= thr_cfg_ff;
          end
        endcase
      end
    end
  end

  // ==========================================
  // read channel: one cycle from address to data
  assign arready = ce && !rvalid;
  wire [`LEDE_IDX_W-1:0] rd_idx = araddr[15:2];

  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_idx)
      `LEDE_IDX_THRESH: rd_mux = {16'h0000, thr_rpt_ff};
      `LEDE_IDX_CFG1: rd_mux = {24'h000000, thr_cfg_ff};
      `LEDE_IDX_PPINDX: rd_mux = {16'h0000, pk_pos_ff};
      `LEDE_IDX_PPAMPL: rd_mux = {16'h0000, pk_mag_ff};
      `LEDE_IDX_RXANTD: rd_mux = {16'h0000, antd_ff};
      `LEDE_IDX_CFG2: rd_mux = {16'h0000, tuning_cfg_ff};
      `LEDE_IDX_REPC: rd_mux = {16'h0000, replica_coef_ff};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `LEDE_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? `LEDE_RESP_OKAY : `LEDE_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== lede_map.vh ====
// Purpose: constants of the leading edge detector register file
// Assumes: register indices are the printed sub-offsets; byte address = index * 4
// Notes:   definitions only
`ifndef LEDE_MAP_VH
`define LEDE_MAP_VH

// ==========================================
// register indices (byte address is index shifted left by two)
`define LEDE_IDX_W 14
`define LEDE_IDX_THRESH 14'h0000
`define LEDE_IDX_CFG1 14'h0806
`define LEDE_IDX_PPINDX 14'h1000
`define LEDE_IDX_PPAMPL 14'h1002
`define LEDE_IDX_RXANTD 14'h1804
`define LEDE_IDX_CFG2 14'h1806
`define LEDE_IDX_REPC 14'h2804

// ==========================================
// threshold config fields
`define LEDE_NTM_LSB 0
`define LEDE_NTM_MSB 4
`define LEDE_PEAK_NOISE_MULTIPLIER_LSB 5
`define LEDE_PEAK_NOISE_MULTIPLIER_MSB 7

// ==========================================
// reset values
`define LEDE_CFG1_RST 8'h6c
`define LEDE_RXANTD_RST 16'h0000
`define LEDE_CFG2_RST 16'h0000
`define LEDE_REPC_RST 16'h0000
`define LEDE_STATUS_RST 16'h0000

// ==========================================
// bus responses
`define LEDE_RESP_OKAY 2'b00
`define LEDE_RESP_SLVERR 2'b10

`endif

// ==== lede_scan.v ====
// Purpose: single pass scan of accumulator magnitudes for noise, threshold, first path and peak
// Assumes: samples arrive from logic on aclk, first NOISE_LEN samples are noise only
// Notes:   threshold is frozen once the noise window closes
`timescale 1ns/1ps
`include "lede_map.vh"

module lede_scan #(
  parameter IDX_W = 16,
  parameter MAG_W = 16,
  parameter NOISE_LOG2 = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [4:0] noise_threshold_multiplier,
  input wire [2:0] peak_noise_multiplier,
  input wire acc_start,
  input wire acc_valid,
  input wire [MAG_W-1:0] acc_mag,
  input wire acc_last,
  output reg done_ff,
  output reg [MAG_W-1:0] thr_ff,
  output reg [IDX_W-1:0] fp_idx_ff,
  output reg [IDX_W-1:0] pk_idx_ff,
  output reg [MAG_W-1:0] pk_mag_ff
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_NOISE = 2'd1;
  localparam [1:0] ST_SEARCH = 2'd2;
  localparam [31:0] NOISE_END_W = (1 << NOISE_LOG2) - 1;
  localparam [IDX_W-1:0] NOISE_END = NOISE_END_W[IDX_W-1:0];
  localparam SUM_W = MAG_W + NOISE_LOG2;

  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg [IDX_W-1:0] idx_ff;
  reg [SUM_W-1:0] sum_ff;
  reg [MAG_W-1:0] nmax_ff;
  reg found_ff;
  reg [IDX_W-1:0] fp_ff;
  reg [IDX_W-1:0] pi_ff;
  reg [MAG_W-1:0] pm_ff;

  // ==========================================
  // threshold from the noise estimate
  wire [MAG_W-1:0] noise_avg = sum_ff[SUM_W-1:NOISE_LOG2];
  wire [MAG_W+4:0] thr_a = noise_threshold_multiplier * noise_avg;
  wire [MAG_W+2:0] thr_bp = nmax_ff * peak_noise_multiplier;
  // peak_noise_multiplier counts in halves, so 3 gives 1.5
  wire [MAG_W+2:0] thr_b = thr_bp >> 1;
  wire [MAG_W+4:0] thr_big = (thr_a > {2'b00, thr_b}) ? thr_a : {2'b00, thr_b};
  // saturate rather than wrap, a wrapped threshold would fire on noise
  wire [MAG_W-1:0] thr_cur = (|thr_big[MAG_W+4:MAG_W]) ? {MAG_W{1'b1}} : thr_big[MAG_W-1:0];

  wire take = acc_valid && (st_ff != ST_IDLE);
  wire pk_new = take && (acc_mag > pm_ff);
  wire [IDX_W-1:0] nxt_pi = pk_new ? idx_ff : pi_ff;
  wire [MAG_W-1:0] nxt_pm = pk_new ? acc_mag : pm_ff;
  wire fp_hit = take && (st_ff == ST_SEARCH) && !found_ff && (acc_mag >= thr_cur);

  // ==========================================
  // state sequencing
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: nxt_st = ST_IDLE;
      ST_NOISE: begin
        if (acc_valid && acc_last) begin
          nxt_st = ST_IDLE;
        end else if (acc_valid && idx_ff == NOISE_END) begin
          nxt_st = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (acc_valid && acc_last) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    if (acc_start) begin
      nxt_st = ST_NOISE;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= ST_IDLE;
      idx_ff <= {IDX_W{1'b0}};
      sum_ff <= {SUM_W{1'b0}};
      nmax_ff <= {MAG_W{1'b0}};
      found_ff <= 1'b0;
      fp_ff <= {IDX_W{1'b0}};
      pi_ff <= {IDX_W{1'b0}};
      pm_ff <= {MAG_W{1'b0}};
      done_ff <= 1'b0;
      thr_ff <= {MAG_W{1'b0}};
      fp_idx_ff <= {IDX_W{1'b0}};
      pk_idx_ff <= {IDX_W{1'b0}};
      pk_mag_ff <= {MAG_W{1'b0}};
    end else if (ce) begin
      st_ff <= nxt_st;
      done_ff <= 1'b0;
      if (acc_start) begin
        idx_ff <= {IDX_W{1'b0}};
        sum_ff <= {SUM_W{1'b0}};
        nmax_ff <= {MAG_W{1'b0}};
        found_ff <= 1'b0;
        pi_ff <= {IDX_W{1'b0}};
        pm_ff <= {MAG_W{1'b0}};
      end else if (take) begin
        idx_ff <= idx_ff + {{(IDX_W-1){1'b0}}, 1'b1};
        pi_ff <= nxt_pi;
        pm_ff <= nxt_pm;
        if (st_ff == ST_NOISE) begin
          sum_ff <= sum_ff + {{NOISE_LOG2{1'b0}}, acc_mag};
          if (acc_mag > nmax_ff) begin
            nmax_ff <= acc_mag;
          end
        end
        if (fp_hit) begin
          found_ff <= 1'b1;
          fp_ff <= idx_ff;
        end
        if (acc_last) begin
          done_ff <= 1'b1;
          thr_ff <= thr_cur;
          pk_idx_ff <= nxt_pi;
          pk_mag_ff <= nxt_pm;
          // no crossing found: fall back to the peak itself
          fp_idx_ff <= fp_hit ? idx_ff : (found_ff ? fp_ff : nxt_pi);
        end
      end
    end
  end
endmodule

// ==== lede_regs_props.sv ====
// Purpose: concurrent checks on the ports of the detector register file
// Assumes: single clock aclk, synchronous active-low aresetn
// Notes:   write response two edges after both channels are taken
`timescale 1ns/1ps
module lede_regs_props #(
  parameter TS_W = 40
) (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] awaddr,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire [15:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  input wire acc_valid,
  input wire acc_last,
  input wire [TS_W-1:0] rx_stamp_ff,
  input wire rx_stamp_vld_ff
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // sequences
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wr_ro;
    s_wr_taken ##0 (awaddr[15:2] == 14'h0000 || awaddr[15:2] == 14'h1000 || awaddr[15:2] == 14'h1002);
  endsequence
  sequence s_err_resp;
    bvalid && bresp == 2'h2;
  endsequence
  // ==========================================
  // properties
  property p_ro_err; s_wr_ro |-> ##2 s_err_resp; endproperty
  property p_wr_lat; s_wr_taken |=> !bvalid ##1 bvalid; endproperty
  property p_rd_lat; arvalid && arready |=> rvalid; endproperty
  property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
  property p_rd_err; arvalid && arready && araddr[15:2] == 14'h0001 |=> rvalid && rresp == 2'h2 && rdata == 32'h0;
  endproperty
  property p_busy_block; (bvalid |-> !awready && !wready) and (rvalid |-> !arready); endproperty
  property p_vld_pulse; rx_stamp_vld_ff |=> !rx_stamp_vld_ff; endproperty
  property p_stamp_lat; acc_valid && acc_last |-> ##2 rx_stamp_vld_ff; endproperty
  property p_stamp_chg; $changed(rx_stamp_ff) |-> rx_stamp_vld_ff; endproperty
  a_ro_err: assert property (p_ro_err) else $error("read-only write not refused");
  a_wr_lat: assert property (p_wr_lat) else $error("write response timing wrong");
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped early");
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  a_busy_block: assert property (p_busy_block) else $error("ready while busy");
  a_vld_pulse: assert property (p_vld_pulse) else $error("stamp valid too long");
  a_stamp_lat: assert property (p_stamp_lat) else $error("stamp valid missing");
  a_stamp_chg: assert property (p_stamp_chg) else $error("stamp moved off a pass end");
endmodule

// ==== tb_leading_edge_detect_regs.sv ====
// Purpose: register and scan checks of the detector register file
// Assumes: byte address is index times four; noise window of 16 samples
// Notes:   16 noise samples of 4, then 10, 30, 200, 50
`timescale 1ns/1ps
module tb_leading_edge_detect_regs;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg ce = 1'b1;
  reg [15:0] awaddr = 16'h0, araddr = 16'h0, acc_mag = 16'h0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg acc_start = 1'b0, acc_valid = 1'b0, acc_last = 1'b0;
  reg [39:0] raw_receive_timestamp = 40'h0;
  wire awready, wready, bvalid, arready, rvalid, rx_stamp_vld_ff;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [39:0] rx_stamp_ff;
  wire [15:0] tuning_cfg_ff, replica_coef_ff;
  integer mismatches = 0, n_tests = 0, cyc = 0, i, k;
  localparam [23:0] CFGS = 24'h6c07e0;
  localparam [23:0] THRS = 24'h301c0e;
  lede_regs dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .acc_start(acc_start), .acc_valid(acc_valid), .acc_mag(acc_mag), .acc_last(acc_last),
    .raw_receive_timestamp(raw_receive_timestamp), .rx_stamp_ff(rx_stamp_ff), .rx_stamp_vld_ff(rx_stamp_vld_ff),
    .tuning_cfg_ff(tuning_cfg_ff), .replica_coef_ff(replica_coef_ff));
  always #50 aclk = ~aclk;
  // ==========================================
  // helpers
  task chk(input [39:0] got, input [39:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // a hang is counted as a mismatch rather than left to run
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  task wr(input [15:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg aw_d, w_d;
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_d && w_d)) begin
        @(posedge aclk);
        if (awvalid && awready === 1'b1) begin
          aw_d = 1'b1;
          awvalid <= 1'b0;
        end
        if (wvalid && wready === 1'b1) begin
          w_d = 1'b1;
          wvalid <= 1'b0;
        end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      chk({38'h0, bresp}, {38'h0, er});
      bready <= 1'b0;
    end
  endtask
  // rready is raised late on purpose so the response has to stand
  task rd(input [15:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b1;
      @(posedge aclk);
      chk({8'h00, rdata}, {8'h00, ed});
      chk({38'h0, rresp}, {38'h0, er});
      rready <= 1'b0;
    end
  endtask
  function [15:0] smp(input integer n);
    case (n)
      16: smp = 16'h000a;
      17: smp = 16'h001e;
      18: smp = 16'h00c8;
      19: smp = 16'h0032;
      default: smp = 16'h0004;
    endcase
  endfunction
  task scan(input [39:0] raw, input [39:0] exp_st);
    begin
      @(posedge aclk);
      raw_receive_timestamp <= raw;
      acc_start <= 1'b1;
      for (i = 0; i < 20; i = i + 1) begin
        @(posedge aclk);
        acc_start <= 1'b0;
        acc_valid <= 1'b1;
        acc_mag <= smp(i);
        acc_last <= (i == 19);
      end
      @(posedge aclk);
      acc_valid <= 1'b0;
      acc_last <= 1'b0;
      @(posedge aclk);
      #1;
      chk({39'h0, rx_stamp_vld_ff}, 40'h1);
      chk(rx_stamp_ff, exp_st);
    end
  endtask
  // ==========================================
  // tests
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(16'h2018, 32'h0000006c, 2'h0);
    rd(16'h0000, 32'h0, 2'h0);
    rd(16'h4000, 32'h0, 2'h0);
    rd(16'h4008, 32'h0, 2'h0);
    rd(16'h6010, 32'h0, 2'h0);
    $display("test reset_values done");
    wr(16'h6010, 32'hdead1234, 4'hf, 2'h0);
    wr(16'h6010, 32'h0000ab00, 4'h2, 2'h0);
    rd(16'h6010, 32'h0000ab34, 2'h0);
    wr(16'h6010, 32'h00000100, 4'h3, 2'h0);
    wr(16'h6018, 32'h00000607, 4'h3, 2'h0);
    // coefficient 16'h5998 shifted down three for the lowest rate
    wr(16'ha010, 32'h00000b33, 4'h3, 2'h0);
    chk({24'h0, tuning_cfg_ff}, 40'h607);
    chk({24'h0, replica_coef_ff}, 40'hb33);
    $display("test rw_lanes done");
    wr(16'h0000, 32'h0000ffff, 4'h3, 2'h2);
    wr(16'h4000, 32'h0000ffff, 4'h3, 2'h2);
    // read-only report locations are only read: writing them is refused with SLVERR
    wr(16'h4008, 32'hffffffff, 4'hf, 2'h2);
    rd(16'h0004, 32'h0, 2'h2);
    rd(16'h0000, 32'h0, 2'h0);
    rd(16'h4000, 32'h0, 2'h0);
    rd(16'h4008, 32'h0, 2'h0);
    @(posedge aclk);
    ce <= 1'b0;
    @(posedge aclk);
    #1;
    chk({37'h0, awready, wready, arready}, 40'h0);
    @(posedge aclk);
    ce <= 1'b1;
    $display("test refusals done");
    for (k = 0; k < 3; k = k + 1) begin
      wr(16'h2018, {24'hffffff, CFGS[8*(2-k) +: 8]}, 4'h1, 2'h0);
      rd(16'h2018, {24'h0, CFGS[8*(2-k) +: 8]}, 2'h0);
      scan(40'h1000000000, 40'h1000000000 - 40'h100 - ((k == 0) ? 40'h0 : 40'h40));
      rd(16'h0000, {24'h0, THRS[8*(2-k) +: 8]}, 2'h0);
      rd(16'h4000, 32'h00000012, 2'h0);
      rd(16'h4008, 32'h000000c8, 2'h0);
    end
    $display("test scans done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(rx_stamp_ff, 40'h0);
    chk({24'h0, tuning_cfg_ff}, 40'h0);
    rd(16'h2018, 32'h0000006c, 2'h0);
    rd(16'h0000, 32'h0, 2'h0);
    rd(16'h6010, 32'h0, 2'h0);
    $display("test mid_reset done");
    tally_and_finish;
  end
endmodule
bind lede_regs lede_regs_props #(.TS_W(TS_W)) u_props (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .acc_valid(acc_valid), .acc_last(acc_last), .rx_stamp_ff(rx_stamp_ff),
  .rx_stamp_vld_ff(rx_stamp_vld_ff));
